// [design/ckm_regs.svh]
// register map, field positions and timing counts of the clock/mode block
`ifndef CKM_REGS_SVH
`define CKM_REGS_SVH
`define CKM_ADDR_CFG 8'h08
`define CKM_ADDR_STAT 8'h0c
`define CKM_ADDR_RST 8'h0d
`define CKM_ADDR_OUT 8'h0e
`define CKM_RST_KEY 8'hff
`define CKM_CFG_RESET 8'h00
`define CKM_OUT_RESET 8'h00
`define CKM_CFG_DET_BIT 1
`define CKM_STAT_EXT_BIT 0
`define CKM_OUT_AS_GPO_BIT 2
`define CKM_OUT_GPO_BIT 1
`define CKM_OUT_IRQ_BIT 0
`define CKM_CLK_HZ 50000000
`define CKM_SLOW_HZ 32000
`define CKM_DET_MIN_HZ 15000
`define CKM_SYNC_PULSE_PIN_IN_PER 2
`define CKM_SYNC_PULSE_PIN_OUT_PER 3
`define CKM_STARTUP_PIN_US 1000
`define CKM_STARTUP_BIT_US 500
`define CKM_SLOW_CYC (`CKM_CLK_HZ / `CKM_SLOW_HZ)
`define CKM_DET_CYC (`CKM_CLK_HZ / `CKM_DET_MIN_HZ)
`define CKM_SYNC_PULSE_PIN_IN_CYC \
   ((`CKM_SYNC_PULSE_PIN_IN_PER * `CKM_CLK_HZ + `CKM_SLOW_HZ - 1) / `CKM_SLOW_HZ)
`define CKM_SYNC_PULSE_PIN_OUT_CYC (`CKM_SYNC_PULSE_PIN_OUT_PER * `CKM_CLK_HZ / `CKM_SLOW_HZ)
`define CKM_STARTUP_PIN_CYC (`CKM_CLK_HZ / 1000000 * `CKM_STARTUP_PIN_US)
`define CKM_STARTUP_BIT_CYC (`CKM_CLK_HZ / 1000000 * `CKM_STARTUP_BIT_US)
`endif

// [design/ckm_pkg.sv]
// types of the clock/mode block
package ckm_pkg;
   typedef enum logic [3:0] {
      CKM_ST_RESET = 4'h1,
      CKM_ST_STANDBY = 4'h2,
      CKM_ST_STARTUP = 4'h4,
      CKM_ST_NORMAL = 4'h8
   } ckm_mode_e;
   typedef enum logic [1:0] {
      CKM_SRC_NONE = 2'h0,
      CKM_SRC_PIN = 2'h1,
      CKM_SRC_AUTO = 2'h2,
      CKM_SRC_INT = 2'h3
   } ckm_src_e;
endpackage

// [design/ckm_sync2.sv]
// two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module ckm_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// [design/ckm_ctrl.sv]
// clock select, detector, output pins, trigger line and mode sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ckm_regs.svh"
module ckm_ctrl #(
   parameter int SYNC_PULSE_PIN_OUT_CYC = `CKM_SYNC_PULSE_PIN_OUT_CYC,
   parameter int STARTUP_PIN_CYC = `CKM_STARTUP_PIN_CYC,
   parameter int STARTUP_BIT_CYC = `CKM_STARTUP_BIT_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic slow_clock_pin,
   input wire logic power_on_pin,
   input wire logic chip_run_set,
   input wire logic chip_run_clr,
   input wire logic thermal_shutdown,
   input wire logic irq_req,
   input wire logic sync_pulse_pin_send,
   input wire logic sync_pulse_pin_i,
   output logic sync_pulse_pin_o,
   output logic sync_pulse_pin_oe_n,
   output logic general_output_pin,
   output logic irq_pin_o,
   output logic irq_pin_oe_n,
   output logic engine_tick,
   output logic sync_pulse_pin_received,
   output logic chip_run,
   output ckm_pkg::ckm_mode_e mode,
   output logic outside_clock_in_use
);
   import ckm_pkg::*;

   localparam int SLOW_CYC = `CKM_SLOW_CYC;
   localparam int DET_CYC = `CKM_DET_CYC;
   localparam int SYNC_PULSE_PIN_IN_CYC = `CKM_SYNC_PULSE_PIN_IN_CYC;

   ckm_mode_e state_q;
   logic rst_i;
   logic soft_rst_q;
   logic wr_ok;
   logic active;
   logic [7:0] cfg_q;
   logic [7:0] out_q;
   logic [7:0] cfg_eff_q;
   logic [7:0] out_eff_q;
   logic chip_run_q;
   logic pin_low_seen_q;
   logic [15:0] start_cnt_q;
   logic ext_s;
   logic ext_d_q;
   logic ext_rise;
   logic [11:0] det_cnt_q;
   logic present_q;
   logic ext_used;
   logic [10:0] int_cnt_q;
   logic int_tick;
   logic want_ext;
   logic sel_q;
   logic sync_pulse_pin_s;
   logic [11:0] sync_pulse_pin_low_cnt_q;
   logic [15:0] sync_pulse_pin_out_cnt_q;
   logic [15:0] out_low_len_q;
   ckm_src_e src;

   assign rst_i = srst | soft_rst_q;
   assign active = (state_q == CKM_ST_NORMAL);
   assign mode = state_q;
   assign chip_run = chip_run_q;
   assign src = ckm_src_e'(cfg_eff_q[1:0]);

   ////////////////////////////////////////////////////////////////////////////
   // register port
   assign wr_ok = reg_we & power_on_pin & (state_q != CKM_ST_RESET);

   always_ff @(posedge clk) begin
      if (srst) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_ok && reg_addr == `CKM_ADDR_RST &&
            reg_wdata == `CKM_RST_KEY;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         cfg_q <= `CKM_CFG_RESET;
         out_q <= `CKM_OUT_RESET;
      end else if (wr_ok) begin
         if (reg_addr == `CKM_ADDR_CFG) begin
            cfg_q <= reg_wdata;
         end else if (reg_addr == `CKM_ADDR_OUT) begin
            out_q <= {5'h00, reg_wdata[2:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         cfg_eff_q <= `CKM_CFG_RESET;
         out_eff_q <= `CKM_OUT_RESET;
      end else if (active) begin
         cfg_eff_q <= cfg_q;
         out_eff_q <= out_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         if (reg_addr == `CKM_ADDR_CFG) begin
            reg_rdata <= cfg_q;
         end else if (reg_addr == `CKM_ADDR_STAT) begin
            reg_rdata <= {7'h00, ext_used};
         end else if (reg_addr == `CKM_ADDR_OUT) begin
            reg_rdata <= out_q;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencer
   always_ff @(posedge clk) begin
      if (rst_i) begin
         chip_run_q <= 1'b0;
      end else if (active && !power_on_pin) begin
         chip_run_q <= 1'b0;
      end else if (chip_run_set && power_on_pin) begin
         chip_run_q <= 1'b1;
      end else if (chip_run_clr) begin
         chip_run_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         state_q <= CKM_ST_RESET;
         start_cnt_q <= 16'h0000;
         pin_low_seen_q <= 1'b1;
      end else begin
         case (state_q)
            CKM_ST_RESET: begin
               state_q <= CKM_ST_STANDBY;
            end
            CKM_ST_STANDBY: begin
               if (!power_on_pin) begin
                  pin_low_seen_q <= 1'b1;
               end
               if (chip_run_q && power_on_pin) begin
                  state_q <= CKM_ST_STARTUP;
                  pin_low_seen_q <= 1'b0;
                  start_cnt_q <= pin_low_seen_q ?
                     16'(STARTUP_PIN_CYC - 1) : 16'(STARTUP_BIT_CYC - 1);
               end
            end
            CKM_ST_STARTUP: begin
               if (!(chip_run_q && power_on_pin)) begin
                  state_q <= CKM_ST_STANDBY;
               end else if (thermal_shutdown) begin
                  state_q <= CKM_ST_STARTUP;
               end else if (start_cnt_q == 16'h0000) begin
                  state_q <= CKM_ST_NORMAL;
               end else begin
                  start_cnt_q <= start_cnt_q - 16'h0001;
               end
            end
            CKM_ST_NORMAL: begin
               if (!(chip_run_q && power_on_pin)) begin
                  state_q <= CKM_ST_STANDBY;
                  pin_low_seen_q <= !power_on_pin;
               end else if (thermal_shutdown) begin
                  state_q <= CKM_ST_STARTUP;
                  start_cnt_q <= 16'h0000;
               end
            end
            default: begin
               state_q <= CKM_ST_RESET;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outside clock detector
   ckm_sync2 u_ext_sync (
      .clk(clk),
      .srst(srst),
      .d(slow_clock_pin),
      .q(ext_s)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         ext_d_q <= 1'b0;
      end else begin
         ext_d_q <= ext_s;
      end
   end

   assign ext_rise = ext_s & ~ext_d_q;

   always_ff @(posedge clk) begin
      if (rst_i) begin
         det_cnt_q <= 12'(DET_CYC);
         present_q <= 1'b0;
      end else if (ext_rise) begin
         det_cnt_q <= 12'h000;
         present_q <= 1'b1;
      end else if (det_cnt_q != 12'(DET_CYC)) begin
         det_cnt_q <= det_cnt_q + 12'h001;
         if (det_cnt_q == 12'(DET_CYC - 1)) begin
            present_q <= 1'b0;
         end
      end
   end

   assign ext_used = cfg_eff_q[`CKM_CFG_DET_BIT] & present_q;
   assign outside_clock_in_use = ext_used;

   ////////////////////////////////////////////////////////////////////////////
   // engine clock select
   always_ff @(posedge clk) begin
      if (rst_i || int_tick) begin
         int_cnt_q <= 11'h000;
      end else begin
         int_cnt_q <= int_cnt_q + 11'h001;
      end
   end

   assign int_tick = (int_cnt_q == 11'(SLOW_CYC - 1));

   always_comb begin
      case (src)
         CKM_SRC_PIN: want_ext = 1'b1;
         CKM_SRC_AUTO: want_ext = ext_used;
         default: want_ext = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         sel_q <= 1'b0;
      end else if (sel_q ? (ext_rise || !present_q) : int_tick) begin
         sel_q <= want_ext;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i) begin
         engine_tick <= 1'b0;
      end else begin
         engine_tick <= active && (sel_q ? ext_rise : int_tick);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // general output and irq pins
   always_ff @(posedge clk) begin
      if (rst_i) begin
         general_output_pin <= 1'b0;
         irq_pin_o <= 1'b0;
         irq_pin_oe_n <= 1'b1;
      end else if (out_eff_q[`CKM_OUT_AS_GPO_BIT]) begin
         general_output_pin <= out_eff_q[`CKM_OUT_GPO_BIT];
         irq_pin_o <= out_eff_q[`CKM_OUT_IRQ_BIT];
         irq_pin_oe_n <= 1'b0;
      end else begin
         general_output_pin <= out_eff_q[`CKM_OUT_GPO_BIT];
         irq_pin_o <= 1'b0;
         irq_pin_oe_n <= !(active && irq_req);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger line
   ckm_sync2 #(
      .RST_VAL(1'b1)
   ) u_sync_pulse_pin_sync (
      .clk(clk),
      .srst(srst),
      .d(sync_pulse_pin_i),
      .q(sync_pulse_pin_s)
   );

   always_ff @(posedge clk) begin
      if (rst_i || sync_pulse_pin_s || !sync_pulse_pin_oe_n) begin
         sync_pulse_pin_low_cnt_q <= 12'h000;
         sync_pulse_pin_received <= 1'b0;
      end else if (sync_pulse_pin_low_cnt_q != 12'(SYNC_PULSE_PIN_IN_CYC)) begin
         sync_pulse_pin_low_cnt_q <= sync_pulse_pin_low_cnt_q + 12'h001;
         sync_pulse_pin_received <= active &&
            (sync_pulse_pin_low_cnt_q == 12'(SYNC_PULSE_PIN_IN_CYC - 1));
      end else begin
         sync_pulse_pin_received <= 1'b0;
      end
   end

   assign sync_pulse_pin_o = 1'b0;

   always_ff @(posedge clk) begin
      if (rst_i) begin
         sync_pulse_pin_out_cnt_q <= 16'h0000;
         sync_pulse_pin_oe_n <= 1'b1;
      end else if (sync_pulse_pin_out_cnt_q != 16'h0000) begin
         sync_pulse_pin_out_cnt_q <= sync_pulse_pin_out_cnt_q - 16'h0001;
         sync_pulse_pin_oe_n <= (sync_pulse_pin_out_cnt_q == 16'h0001);
      end else if (sync_pulse_pin_send && active) begin
         sync_pulse_pin_out_cnt_q <= 16'(SYNC_PULSE_PIN_OUT_CYC);
         sync_pulse_pin_oe_n <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_i || sync_pulse_pin_oe_n) begin
         out_low_len_q <= 16'h0000;
      end else begin
         out_low_len_q <= out_low_len_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_i);

   property p_present_on_edge;
      ext_rise |=> present_q;
   endproperty
   a_present_on_edge: assert property (p_present_on_edge)
      else $error("edge on outside clock not reported present");

   property p_absent_when_stuck;
      (det_cnt_q == 12'(DET_CYC)) |-> !present_q;
   endproperty
   a_absent_when_stuck: assert property (p_absent_when_stuck)
      else $error("stuck outside clock still reported present");

   property p_status_needs_detector;
      (reg_re && reg_addr == `CKM_ADDR_STAT) |=>
         reg_rdata == {7'h00, $past(cfg_eff_q[`CKM_CFG_DET_BIT]) &&
         $past(present_q)};
   endproperty
   a_status_needs_detector: assert property (p_status_needs_detector)
      else $error("status read does not match detector result");

   property p_irq_open_drain;
      (!out_eff_q[`CKM_OUT_AS_GPO_BIT] && active && irq_req) |=>
         (!irq_pin_oe_n && !irq_pin_o);
   endproperty
   a_irq_open_drain: assert property (p_irq_open_drain)
      else $error("interrupt not pulled low");

   property p_irq_as_output;
      out_eff_q[`CKM_OUT_AS_GPO_BIT] |=>
         (!irq_pin_oe_n && irq_pin_o == $past(out_eff_q[`CKM_OUT_IRQ_BIT]));
   endproperty
   a_irq_as_output: assert property (p_irq_as_output)
      else $error("irq pin output level wrong");

   property p_sync_pulse_pin_out_length;
      $rose(sync_pulse_pin_oe_n) |->
         $past(out_low_len_q) == 16'(SYNC_PULSE_PIN_OUT_CYC - 1);
   endproperty
   a_sync_pulse_pin_out_length: assert property (p_sync_pulse_pin_out_length)
      else $error("trigger output length wrong");

   property p_sync_pulse_pin_in_length;
      sync_pulse_pin_received |-> $past(sync_pulse_pin_low_cnt_q) == 12'(SYNC_PULSE_PIN_IN_CYC - 1);
   endproperty
   a_sync_pulse_pin_in_length: assert property (p_sync_pulse_pin_in_length)
      else $error("trigger accepted before minimum low time");

   property p_reset_to_standby;
      (state_q == CKM_ST_RESET) |=>
         (state_q == CKM_ST_STANDBY) && !chip_run_q;
   endproperty
   a_reset_to_standby: assert property (p_reset_to_standby)
      else $error("reset did not lead to standby");

   property p_stay_standby;
      (state_q == CKM_ST_STANDBY && !(chip_run_q && power_on_pin)) |=>
         state_q == CKM_ST_STANDBY;
   endproperty
   a_stay_standby: assert property (p_stay_standby)
      else $error("left standby without run bit and power pin");

   property p_pin_low_clears_run;
      (active && !power_on_pin) |=> !chip_run_q &&
         state_q == CKM_ST_STANDBY;
   endproperty
   a_pin_low_clears_run: assert property (p_pin_low_clears_run)
      else $error("power pin low did not clear run bit");

   property p_thermal_holds;
      (state_q == CKM_ST_STARTUP && thermal_shutdown && chip_run_q &&
         power_on_pin) |=> state_q == CKM_ST_STARTUP;
   endproperty
   a_thermal_holds: assert property (p_thermal_holds)
      else $error("start-up left during thermal shutdown");
endmodule
`default_nettype wire

// [bench/ckm_far_end.sv]
// far-side model: outside slow clock source and a trigger line party
`timescale 1ns/1ns
`default_nettype none
module ckm_far_end (
   input wire logic clk,
   input wire logic clk_run,
   input wire logic clk_stuck,
   input wire logic [15:0] half_per,
   input wire logic hold_low,
   input wire logic dev_o,
   input wire logic dev_oe_n,
   output logic slow_clk,
   output logic sync_pulse_pin_wire
);
   logic [15:0] cnt_q;
   ////////////////////////////////////////
   // free-running slow clock or a stuck level
   always @(posedge clk) begin
      if (!clk_run) begin
         slow_clk <= clk_stuck;
         cnt_q <= 16'h0000;
      end else if (cnt_q >= half_per - 16'h0001) begin
         slow_clk <= ~slow_clk;
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   ////////////////////////////////////////
   // wired-and trigger line with pull-up
   assign sync_pulse_pin_wire = (dev_oe_n ? 1'b1 : dev_o) & ~hold_low;
endmodule
`default_nettype wire

// [bench/test_clock_select_io_and_mode_ctrl.sv]
// self-checking bench of the clock/mode block
`timescale 1ns/1ns
`default_nettype none
module test_clock_select_io_and_mode_ctrl;
   import ckm_pkg::*;
   localparam int TOC = 10;
   localparam int SPC = 20;
   localparam int SBC = 10;
   localparam int TIN = 3125;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic power_on_pin = 1'b0;
   logic chip_run_set = 1'b0;
   logic chip_run_clr = 1'b0;
   logic thermal_shutdown = 1'b0;
   logic irq_req = 1'b0;
   logic sync_pulse_pin_send = 1'b0;
   logic clk_run = 1'b0;
   logic clk_stuck = 1'b0;
   logic [15:0] half_per = 16'h02bc;
   logic hold_low = 1'b0;
   logic [7:0] reg_rdata;
   logic slow_clk, sync_pulse_pin_wire, sync_o, sync_oe_n, output_pin_control, irq_o, irq_oe_n;
   logic engine_tick, sync_pulse_pin_received, chip_run, ext_used;
   ckm_mode_e mode;
   int n_errors = 0;
   int samples_checked = 0;
   int n;
   int k;
   logic [7:0] t_cfg [5] = '{8'h03, 8'h02, 8'h01, 8'h02, 8'h02};
   logic t_run [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic t_stk [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [15:0] t_half [5] = '{16'h02bc, 16'h02bc, 16'h0384, 16'h02bc,
      16'h02bc};
   int t_per [5] = '{1562, 1400, 1800, 1562, 1562};
   logic t_st [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

   ckm_ctrl #(
      .SYNC_PULSE_PIN_OUT_CYC(TOC),
      .STARTUP_PIN_CYC(SPC),
      .STARTUP_BIT_CYC(SBC)
   ) ckm_ctrl_inst (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .slow_clock_pin(slow_clk), .power_on_pin(power_on_pin),
      .chip_run_set(chip_run_set), .chip_run_clr(chip_run_clr),
      .thermal_shutdown(thermal_shutdown), .irq_req(irq_req),
      .sync_pulse_pin_send(sync_pulse_pin_send), .sync_pulse_pin_i(sync_pulse_pin_wire),
      .sync_pulse_pin_o(sync_o), .sync_pulse_pin_oe_n(sync_oe_n),
      .general_output_pin(output_pin_control), .irq_pin_o(irq_o), .irq_pin_oe_n(irq_oe_n),
      .engine_tick(engine_tick), .sync_pulse_pin_received(sync_pulse_pin_received),
      .chip_run(chip_run), .mode(mode), .outside_clock_in_use(ext_used)
   );
   ckm_far_end ckm_far_end_inst (
      .clk(clk), .clk_run(clk_run), .clk_stuck(clk_stuck),
      .half_per(half_per), .hold_low(hold_low), .dev_o(sync_o),
      .dev_oe_n(sync_oe_n), .slow_clk(slow_clk), .sync_pulse_pin_wire(sync_pulse_pin_wire)
   );

   always #10 clk = ~clk;
   ////////////////////////////////////////
   // helpers
   task automatic summarize;
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tk;
      @(posedge clk);
      #1;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic strobe(input int w);
      @(posedge clk);
      case (w)
         0: chip_run_set <= 1'b1;
         1: chip_run_clr <= 1'b1;
         default: sync_pulse_pin_send <= 1'b1;
      endcase
      @(posedge clk);
      chip_run_set <= 1'b0;
      chip_run_clr <= 1'b0;
      sync_pulse_pin_send <= 1'b0;
      #1;
   endtask
   task automatic wait_mode(input ckm_mode_e m, input int lim, output int c);
      c = 0;
      while (mode !== m) begin
         tk();
         c++;
         if (c > lim) begin
            n_errors++;
            summarize();
         end
      end
   endtask
   task automatic tick_per(output int p);
      p = 0;
      tk();
      while (engine_tick !== 1'b1 && p < 20000) begin
         tk();
         p++;
      end
      p = 0;
      do begin
         tk();
         p++;
      end while (engine_tick !== 1'b1 && p < 20000);
      if (p >= 20000) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic pull(input int len, input int e);
      int c;
      c = 0;
      @(posedge clk);
      hold_low <= 1'b1;
      for (int i = 0; i < len + 40; i++) begin
         @(posedge clk);
         if (i == len)
            hold_low <= 1'b0;
         #1;
         c += int'(sync_pulse_pin_received === 1'b1);
      end
      chk("sync_pulse_pin_received", c, e);
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (19) @(posedge clk);
      #1;
      chk("mode", mode, CKM_ST_RESET);
      @(posedge clk);
      srst <= 1'b0;
      cyc(2);
      #1;
      chk("mode", mode, CKM_ST_STANDBY);
      chk("chip_run", chip_run, 0);
      chk("sync_pulse_pin_oe_n", sync_oe_n, 1);
      rd(8'h08, 8'h00);
      rd(8'h0e, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h08, 8'h03);
      rd(8'h08, 8'h00);
      @(posedge clk);
      power_on_pin <= 1'b1;
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h07);
      chk("gpo", output_pin_control, 0);
      chk("irq_oe_n", irq_oe_n, 1);
      strobe(0);
      wait_mode(CKM_ST_NORMAL, 100, n);
      chk("startup_pin", n >= SPC - 1 && n <= SPC + 3, 1);
      cyc(3);
      #1;
      chk("gpo", output_pin_control, 1);
      chk("irq_o", irq_o, 1);
      chk("irq_oe_n", irq_oe_n, 0);
      wr(8'h0e, 8'h06);
      cyc(3);
      #1;
      chk("irq_o", irq_o, 0);
      wr(8'h0e, 8'h00);
      irq_req <= 1'b1;
      cyc(3);
      #1;
      chk("irq_oe_n", irq_oe_n, 0);
      chk("gpo", output_pin_control, 0);
      @(posedge clk);
      irq_req <= 1'b0;
      cyc(3);
      #1;
      chk("irq_oe_n", irq_oe_n, 1);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         clk_run <= t_run[i];
         clk_stuck <= t_stk[i];
         half_per <= t_half[i];
         wr(8'h08, t_cfg[i]);
         cyc(4000);
         if (t_cfg[i][1]) begin
            rd(8'h0c, {7'h00, t_st[i]});
            chk("ext_used", ext_used, t_st[i]);
         end
         tick_per(k);
         tick_per(k);
         chk("tick_period", k, t_per[i]);
      end
      strobe(2);
      k = 0;
      while (sync_oe_n !== 1'b0 && k < 5) begin
         tk();
         k++;
      end
      chk("sync_pulse_pin_wire", sync_pulse_pin_wire, 0);
      n = 0;
      while (sync_oe_n === 1'b0 && n < 100) begin
         tk();
         n++;
      end
      chk("sync_pulse_pin_out_len", n, TOC);
      pull(1000, 0);
      pull(TIN + 200, 1);
      @(posedge clk);
      thermal_shutdown <= 1'b1;
      cyc(100);
      #1;
      chk("mode", mode, CKM_ST_STARTUP);
      @(posedge clk);
      thermal_shutdown <= 1'b0;
      wait_mode(CKM_ST_NORMAL, 5, n);
      wr(8'h0e, 8'h07);
      wr(8'h0d, 8'hff);
      cyc(3);
      #1;
      chk("mode", mode, CKM_ST_STANDBY);
      chk("chip_run", chip_run, 0);
      rd(8'h0e, 8'h00);
      rd(8'h08, 8'h00);
      strobe(0);
      wait_mode(CKM_ST_NORMAL, 100, n);
      @(posedge clk);
      irq_req <= 1'b1;
      strobe(1);
      cyc(3);
      #1;
      chk("mode", mode, CKM_ST_STANDBY);
      chk("irq_oe_n", irq_oe_n, 1);
      k = 0;
      repeat (2000) begin
         tk();
         k += int'(engine_tick === 1'b1);
      end
      chk("ticks", k, 0);
      strobe(0);
      wait_mode(CKM_ST_NORMAL, 100, n);
      chk("startup_bit", n >= SBC - 1 && n <= SBC + 3, 1);
      @(posedge clk);
      power_on_pin <= 1'b0;
      cyc(3);
      #1;
      chk("chip_run", chip_run, 0);
      chk("mode", mode, CKM_ST_STANDBY);
      summarize();
   end
endmodule
`default_nettype wire
